// ==== core/crs_regs.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Sixteen general, three control, four system registers.
// - General register zero doubles as index register.
// - Register fifteen is stack pointer for exceptions.
// - Global base supplies peripheral access base address.
// - Vector base locates exception and interrupt vectors.
// - Multiply-accumulate pair holds multiply results.
// - Return link holds subroutine return address.
// - Program counter holds executing program address.
// - Reset loads stack pointer from vector table.
// - Reset sets interrupt mask ones, reserved zero.
// - Reset loads program counter from vector table.
// - Byte and word loads are sign-extended.
module crs_regs (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   output logic vec_rd_req_o,
   output logic [31:0] vec_rd_addr_o,
   input wire logic vec_rd_valid_i,
   input wire logic [31:0] vec_rd_data_i,
   output logic init_done_o,
   input wire logic [3:0] rd_a_sel_i,
   input wire logic [3:0] rd_b_sel_i,
   output logic [31:0] rd_a_data_o,
   output logic [31:0] rd_b_data_o,
   input wire logic wr_we_i,
   input wire logic [3:0] wr_sel_i,
   input wire logic [31:0] wr_data_i,
   input wire logic ld_we_i,
   input wire logic [3:0] ld_sel_i,
   input wire crs_pkg::crs_size_t ld_size_i,
   input wire logic [31:0] ld_data_i,
   input wire logic sp_dec_i,
   input wire logic sp_inc_i,
   input wire logic ctl_we_i,
   input wire crs_pkg::crs_ctl_t ctl_sel_i,
   input wire logic [31:0] ctl_data_i,
   input wire logic mac_we_i,
   input wire logic [31:0] mac_high_i,
   input wire logic [31:0] mac_low_i,
   input wire logic pr_we_i,
   input wire logic [31:0] pr_data_i,
   input wire logic pc_load_i,
   input wire logic [31:0] pc_target_i,
   input wire logic pc_step_i,
   input wire logic [31:0] gbr_disp_i,
   input wire logic [7:0] vec_num_i,
   output logic [31:0] index_reg_o,
   output logic [31:0] stack_pointer_reg_o,
   output logic [31:0] status_word_o,
   output logic [3:0] interrupt_mask_bits_o,
   output logic [31:0] global_base_reg_o,
   output logic [31:0] vector_base_reg_o,
   output logic [31:0] mul_acc_high_o,
   output logic [31:0] mul_acc_low_o,
   output logic [31:0] return_link_reg_o,
   output logic [31:0] program_counter_o,
   output logic [31:0] gbr_ea_o,
   output logic [31:0] vec_ea_o
);
   import crs_pkg::*;

   crs_state_t state_q, state_d;
   logic req_q, req_d;
   logic [31:0] vaddr_q, vaddr_d;
   logic run, take_pc, take_sp;
   logic [31:0] ld_ext;
   logic [31:0] gpr_view [NUM_GPR];
   logic [31:0] rda_q, rda_d, rdb_q, rdb_d;
   logic [31:0] sr_q, sr_d, gbr_q, gbr_d, vbr_q, vbr_d;
   logic [31:0] mul_acc_high_q, mul_acc_high_d, mul_acc_low_q, mul_acc_low_d, pr_q, pr_d;
   logic [31:0] pc_q, pc_d, gea_q, gea_d, vea_q, vea_d;

   // ==========================================================
   // Reset vector fetch sequencer
   always_comb begin
      state_d = state_q;
      req_d = req_q;
      vaddr_d = vaddr_q;
      take_pc = 1'b0;
      take_sp = 1'b0;
      case (state_q)
         CRS_ST_FETCH_PC: begin
            if (vec_rd_valid_i) begin
               take_pc = 1'b1;
               vaddr_d = vbr_q + VEC_SP_OFS;
               state_d = CRS_ST_FETCH_SP;
            end
         end
         CRS_ST_FETCH_SP: begin
            if (vec_rd_valid_i) begin
               take_sp = 1'b1;
               req_d = 1'b0;
               state_d = CRS_ST_RUN;
            end
         end
         CRS_ST_RUN: begin
            req_d = 1'b0;
         end
         default: begin
            state_d = CRS_ST_FETCH_PC;
            req_d = 1'b1;
            vaddr_d = VEC_PC_OFS;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_q <= CRS_ST_FETCH_PC;
         req_q <= 1'b1;
         vaddr_q <= VEC_PC_OFS;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         vaddr_q <= vaddr_d;
      end
   end

   // Pipeline writes are ignored until both vectors are in
   assign run = (state_q == CRS_ST_RUN);

   // ==========================================================
   // General registers
   crs_load_ext u_load_ext (
      .size_i(ld_size_i),
      .data_i(ld_data_i),
      .ext_o(ld_ext)
   );

   for (genvar g = 0; g < NUM_GPR; g++) begin : g_gpr
      logic [31:0] q, d;
      always_comb begin
         d = q;
         if (4'(g) == SP_REG_NUM) begin
            if (take_sp) begin
               d = vec_rd_data_i;
            end else if (run && sp_dec_i) begin
               d = q - STACK_SLOT;
            end else if (run && sp_inc_i) begin
               d = q + STACK_SLOT;
            end
         end
         if (run && wr_we_i && wr_sel_i == 4'(g)) begin
            d = wr_data_i;
         end
         // Load beats the other ports on the same register
         if (run && ld_we_i && ld_sel_i == 4'(g)) begin
            d = ld_ext;
         end
      end
      // Zeroed at reset only to keep simulation free of X
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) begin
            q <= DATA_RESET;
         end else begin
            q <= d;
         end
      end
      assign gpr_view[g] = q;
   end

   // Read ports are registered; same-cycle writes are not bypassed
   always_comb begin
      rda_d = gpr_view[rd_a_sel_i];
      rdb_d = gpr_view[rd_b_sel_i];
   end

   // ==========================================================
   // Control, system and address registers
   always_comb begin
      sr_d = sr_q;
      gbr_d = gbr_q;
      vbr_d = vbr_q;
      mul_acc_high_d = mul_acc_high_q;
      mul_acc_low_d = mul_acc_low_q;
      pr_d = pr_q;
      pc_d = pc_q;
      if (run && ctl_we_i) begin
         case (ctl_sel_i)
            CRS_CTL_SR: sr_d = ctl_data_i & SR_IMPL_MASK;
            CRS_CTL_GBR: gbr_d = ctl_data_i;
            CRS_CTL_VBR: vbr_d = ctl_data_i;
            default: sr_d = sr_q;
         endcase
      end
      if (run && mac_we_i) begin
         mul_acc_high_d = mac_high_i;
         mul_acc_low_d = mac_low_i;
      end
      if (run && pr_we_i) begin
         pr_d = pr_data_i;
      end
      if (take_pc) begin
         pc_d = vec_rd_data_i;
      end else if (run && pc_load_i) begin
         pc_d = pc_target_i;
      end else if (run && pc_step_i) begin
         pc_d = pc_q + INSTR_STEP;
      end
      gea_d = gbr_q + gbr_disp_i;
      vea_d = vbr_q + {22'h000000, vec_num_i, 2'h0};
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sr_q <= SR_RESET;
         gbr_q <= DATA_RESET;
         vbr_q <= VBR_RESET;
         mul_acc_high_q <= DATA_RESET;
         mul_acc_low_q <= DATA_RESET;
         pr_q <= DATA_RESET;
         pc_q <= DATA_RESET;
         gea_q <= DATA_RESET;
         vea_q <= DATA_RESET;
         rda_q <= DATA_RESET;
         rdb_q <= DATA_RESET;
      end else begin
         sr_q <= sr_d;
         gbr_q <= gbr_d;
         vbr_q <= vbr_d;
         mul_acc_high_q <= mul_acc_high_d;
         mul_acc_low_q <= mul_acc_low_d;
         pr_q <= pr_d;
         pc_q <= pc_d;
         gea_q <= gea_d;
         vea_q <= vea_d;
         rda_q <= rda_d;
         rdb_q <= rdb_d;
      end
   end

   // ==========================================================
   // Outputs
   assign vec_rd_req_o = req_q;
   assign vec_rd_addr_o = vaddr_q;
   assign init_done_o = state_q[2];
   assign rd_a_data_o = rda_q;
   assign rd_b_data_o = rdb_q;
   assign index_reg_o = gpr_view[IDX_REG_NUM];
   assign stack_pointer_reg_o = gpr_view[SP_REG_NUM];
   assign status_word_o = sr_q;
   assign interrupt_mask_bits_o = sr_q[SR_IMASK_LSB +: SR_IMASK_W];
   assign global_base_reg_o = gbr_q;
   assign vector_base_reg_o = vbr_q;
   assign mul_acc_high_o = mul_acc_high_q;
   assign mul_acc_low_o = mul_acc_low_q;
   assign return_link_reg_o = pr_q;
   assign program_counter_o = pc_q;
   assign gbr_ea_o = gea_q;
   assign vec_ea_o = vea_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   property p_sp_vector;
      state_q == CRS_ST_FETCH_SP && vec_rd_valid_i
         |=> stack_pointer_reg_o == $past(vec_rd_data_i) ##0 run;
   endproperty
   a_sp_vector: assert property (p_sp_vector)
      else $error("stack pointer not taken from vector");
   property p_pc_vector;
      state_q == CRS_ST_FETCH_PC && vec_rd_valid_i
         |=> program_counter_o == $past(vec_rd_data_i)
             ##0 vec_rd_addr_o == VEC_SP_OFS;
   endproperty
   a_pc_vector: assert property (p_pc_vector)
      else $error("program counter not taken from vector");
   property p_sr_reset;
      $rose(rst_n_i) |-> interrupt_mask_bits_o == SR_IMASK_RESET
         && (status_word_o & ~SR_IMPL_MASK) == 32'h0000_0000;
   endproperty
   a_sr_reset: assert property (p_sr_reset)
      else $error("status word reset value wrong");
   property p_vbr_reset;
      $rose(rst_n_i) |-> vector_base_reg_o == VBR_RESET && vec_rd_req_o;
   endproperty
   a_vbr_reset: assert property (p_vbr_reset)
      else $error("vector base not cleared at reset");
   property p_byte_load;
      run && ld_we_i && ld_size_i == CRS_SZ_BYTE |=> gpr_view[$past(ld_sel_i)]
         == {{24{$past(ld_data_i[7])}}, $past(ld_data_i[7:0])};
   endproperty
   a_byte_load: assert property (p_byte_load)
      else $error("byte load not sign-extended");
   property p_index_write;
      run && wr_we_i && wr_sel_i == IDX_REG_NUM
         && !(ld_we_i && ld_sel_i == IDX_REG_NUM)
         |=> index_reg_o == $past(wr_data_i);
   endproperty
   a_index_write: assert property (p_index_write)
      else $error("index register write lost");
   property p_sp_push;
      run && sp_dec_i && !(wr_we_i && wr_sel_i == SP_REG_NUM)
         && !(ld_we_i && ld_sel_i == SP_REG_NUM)
         |=> stack_pointer_reg_o == $past(stack_pointer_reg_o) - STACK_SLOT;
   endproperty
   a_sp_push: assert property (p_sp_push)
      else $error("stack pointer decrement wrong");
   property p_gbr_ea;
      1'b1 |=> gbr_ea_o == $past(global_base_reg_o) + $past(gbr_disp_i);
   endproperty
   a_gbr_ea: assert property (p_gbr_ea)
      else $error("global base address wrong");

   property p_vec_ea;
      1'b1 |=> vec_ea_o
         == $past(vector_base_reg_o) + {22'h000000, $past(vec_num_i), 2'h0};
   endproperty
   a_vec_ea: assert property (p_vec_ea)
      else $error("vector address wrong");

   property p_mac_write;
      run && mac_we_i |=> mul_acc_high_o == $past(mac_high_i)
         && mul_acc_low_o == $past(mac_low_i);
   endproperty
   a_mac_write: assert property (p_mac_write)
      else $error("multiply result not stored");

   property p_pr_write;
      run && pr_we_i |=> return_link_reg_o == $past(pr_data_i);
   endproperty
   a_pr_write: assert property (p_pr_write)
      else $error("return link not stored");

   property p_pc_step;
      run && pc_step_i && !pc_load_i
         |=> program_counter_o == $past(program_counter_o) + INSTR_STEP;
   endproperty
   a_pc_step: assert property (p_pc_step)
      else $error("program counter step wrong");

endmodule

// ==== core/crs_pkg.sv ====
package crs_pkg;

   // ==========================================================
   // Widths and register numbers
   localparam int unsigned XLEN = 32;
   localparam int unsigned NUM_GPR = 16;
   localparam int unsigned GPR_SEL_W = 4;
   localparam logic [3:0] IDX_REG_NUM = 4'h0;
   localparam logic [3:0] SP_REG_NUM = 4'hF;

   // ==========================================================
   // Status word layout and reset values
   localparam int unsigned SR_IMASK_LSB = 4;
   localparam int unsigned SR_IMASK_W = 4;
   localparam logic [3:0] SR_IMASK_RESET = 4'hF;
   localparam logic [31:0] SR_IMPL_MASK = 32'h0000_03F3;
   localparam logic [31:0] SR_RESET = 32'h0000_00F0;
   localparam logic [31:0] VBR_RESET = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;

   // ==========================================================
   // Vector table and address steps
   localparam logic [31:0] VEC_PC_OFS = 32'h0000_0000;
   localparam logic [31:0] VEC_SP_OFS = 32'h0000_0004;
   localparam logic [31:0] STACK_SLOT = 32'h0000_0004;
   localparam logic [31:0] INSTR_STEP = 32'h0000_0002;

   // ==========================================================
   // Encodings
   typedef enum logic [1:0] {
      CRS_SZ_BYTE = 2'h0,
      CRS_SZ_WORD = 2'h1,
      CRS_SZ_LONG = 2'h2
   } crs_size_t;

   typedef enum logic [1:0] {
      CRS_CTL_SR = 2'h0,
      CRS_CTL_GBR = 2'h1,
      CRS_CTL_VBR = 2'h2
   } crs_ctl_t;

   typedef enum logic [2:0] {
      CRS_ST_FETCH_PC = 3'h1,
      CRS_ST_FETCH_SP = 3'h2,
      CRS_ST_RUN = 3'h4
   } crs_state_t;

endpackage

// ==== core/crs_load_ext.sv ====
`timescale 1ns/1ns
module crs_load_ext (
   input wire crs_pkg::crs_size_t size_i,
   input wire logic [31:0] data_i,
   output logic [31:0] ext_o
);
   import crs_pkg::*;

   // ==========================================================
   // Sign extension of narrow memory operands
   always_comb begin
      case (size_i)
         CRS_SZ_BYTE: ext_o = {{24{data_i[7]}}, data_i[7:0]};
         CRS_SZ_WORD: ext_o = {{16{data_i[15]}}, data_i[15:0]};
         default: ext_o = data_i;
      endcase
   end

endmodule

// ==== bench/crs_vec_model.sv ====
`timescale 1ns/1ns
module crs_vec_model
   import crs_pkg::*;
#(
   parameter logic [31:0] PC_VAL = 32'h0000_0100,
   parameter logic [31:0] SP_VAL = 32'h0000_8000,
   parameter int DLY = 3
) (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   output logic valid_o,
   output logic [31:0] data_o
);
   int cnt;
   initial begin
      valid_o = 1'b0;
      data_o = 32'h5A5A_5A5A;
      cnt = 0;
   end
   // ==========================================================
   // Vector table reader
   // Data toggles outside valid so stale words never look good
   always @(negedge clk_i) begin
      if (valid_o) begin
         valid_o <= 1'b0;
         data_o <= ~data_o;
         cnt <= 0;
      end else if (req_i && cnt >= DLY) begin
         valid_o <= 1'b1;
         data_o <= (addr_i == VEC_SP_OFS) ? SP_VAL : PC_VAL;
      end else begin
         cnt <= req_i ? cnt + 1 : 0;
         data_o <= ~data_o;
      end
   end
endmodule

// ==== bench/cpu_register_set_test.sv ====
`timescale 1ns/1ns
module cpu_register_set_test;
   import crs_pkg::*;
   typedef struct packed {
      logic [2:0] kind;
      logic [3:0] sel;
      logic [1:0] sz;
      logic [31:0] dat;
      logic [31:0] exp;
   } crs_row_t;
   // Kinds: 0 load, 1 write, 2 control, 3 mac, 4 return
   localparam crs_row_t ROWS [12] = '{
      '{0, 3, 0, 32'h0000_0080, 32'hFFFF_FF80},
      '{0, 3, 0, 32'hABCD_127F, 32'h0000_007F},
      '{0, 4, 1, 32'h0000_8001, 32'hFFFF_8001},
      '{0, 4, 1, 32'h1234_7FFF, 32'h0000_7FFF},
      '{0, 5, 2, 32'h8000_0000, 32'h8000_0000},
      '{1, 0, 0, 32'h1234_5678, 32'h1234_5678},
      '{1, 9, 0, 32'hDEAD_BEEF, 32'hDEAD_BEEF},
      '{2, 0, 0, 32'hFFFF_FFFF, SR_IMPL_MASK},
      '{2, 1, 0, 32'h0000_1000, 32'h0000_1000},
      '{2, 2, 0, 32'h0000_0400, 32'h0000_0400},
      '{3, 0, 0, 32'h1234_5678, 32'h1234_5678},
      '{4, 0, 0, 32'h0000_2000, 32'h0000_2000}
   };
   logic clk_sys_i, rst_n_i, vec_rd_req_o, vec_rd_valid_i, init_done_o;
   logic wr_we_i, ld_we_i, sp_dec_i, sp_inc_i, ctl_we_i, mac_we_i;
   logic pr_we_i, pc_load_i, pc_step_i;
   logic [3:0] rd_a_sel_i, rd_b_sel_i, wr_sel_i, ld_sel_i;
   logic [3:0] interrupt_mask_bits_o;
   logic [7:0] vec_num_i;
   crs_size_t ld_size_i;
   crs_ctl_t ctl_sel_i;
   logic [31:0] vec_rd_addr_o, vec_rd_data_i, rd_a_data_o, rd_b_data_o;
   logic [31:0] wr_data_i, ld_data_i, ctl_data_i, mac_high_i, mac_low_i;
   logic [31:0] pr_data_i, pc_target_i, gbr_disp_i, index_reg_o;
   logic [31:0] stack_pointer_reg_o, status_word_o, global_base_reg_o;
   logic [31:0] vector_base_reg_o, mul_acc_high_o, mul_acc_low_o;
   logic [31:0] return_link_reg_o, program_counter_o, gbr_ea_o, vec_ea_o;
   logic [31:0] e;
   int bad_count = 0;
   int samples_checked = 0;

   crs_regs i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .vec_rd_req_o(vec_rd_req_o), .vec_rd_addr_o(vec_rd_addr_o),
      .vec_rd_valid_i(vec_rd_valid_i), .vec_rd_data_i(vec_rd_data_i),
      .init_done_o(init_done_o),
      .rd_a_sel_i(rd_a_sel_i), .rd_b_sel_i(rd_b_sel_i),
      .rd_a_data_o(rd_a_data_o), .rd_b_data_o(rd_b_data_o),
      .wr_we_i(wr_we_i), .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i),
      .ld_we_i(ld_we_i), .ld_sel_i(ld_sel_i), .ld_size_i(ld_size_i),
      .ld_data_i(ld_data_i), .sp_dec_i(sp_dec_i), .sp_inc_i(sp_inc_i),
      .ctl_we_i(ctl_we_i), .ctl_sel_i(ctl_sel_i), .ctl_data_i(ctl_data_i),
      .mac_we_i(mac_we_i), .mac_high_i(mac_high_i), .mac_low_i(mac_low_i),
      .pr_we_i(pr_we_i), .pr_data_i(pr_data_i),
      .pc_load_i(pc_load_i), .pc_target_i(pc_target_i),
      .pc_step_i(pc_step_i), .gbr_disp_i(gbr_disp_i),
      .vec_num_i(vec_num_i), .index_reg_o(index_reg_o),
      .stack_pointer_reg_o(stack_pointer_reg_o),
      .status_word_o(status_word_o),
      .interrupt_mask_bits_o(interrupt_mask_bits_o),
      .global_base_reg_o(global_base_reg_o),
      .vector_base_reg_o(vector_base_reg_o),
      .mul_acc_high_o(mul_acc_high_o), .mul_acc_low_o(mul_acc_low_o),
      .return_link_reg_o(return_link_reg_o),
      .program_counter_o(program_counter_o),
      .gbr_ea_o(gbr_ea_o), .vec_ea_o(vec_ea_o)
   );
   crs_vec_model i_vec (.clk_i(clk_sys_i), .req_i(vec_rd_req_o),
      .addr_i(vec_rd_addr_o), .valid_o(vec_rd_valid_i),
      .data_o(vec_rd_data_i));

   // ==========================================================
   // Helpers
   task automatic chk(input string n, input logic [31:0] s, x);
      samples_checked++;
      if (s !== x) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h seen %h", n, x, s);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic quiet();
      {wr_we_i, ld_we_i, sp_dec_i, sp_inc_i, ctl_we_i} = 5'h00;
      {mac_we_i, pr_we_i, pc_load_i, pc_step_i} = 4'h0;
   endtask
   function automatic logic [31:0] seen(input crs_row_t r);
      case (r.kind)
         3'h2: seen = (r.sel == 4'h0) ? status_word_o :
            (r.sel == 4'h1) ? global_base_reg_o : vector_base_reg_o;
         3'h3: seen = mul_acc_high_o;
         3'h4: seen = return_link_reg_o;
         default: seen = rd_a_data_o;
      endcase
   endfunction
   // Writes held high through init must all be dropped
   task automatic do_reset();
      rst_n_i = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      chk("sr", status_word_o, SR_RESET);
      chk("imask", {28'h0, interrupt_mask_bits_o}, 32'h0000_000F);
      chk("vbr", vector_base_reg_o, VBR_RESET);
      chk("req", {31'h0, vec_rd_req_o}, 32'h0000_0001);
      chk("busy", {31'h0, init_done_o}, 32'h0000_0000);
      chk("vaddr", vec_rd_addr_o, VEC_PC_OFS);
      rst_n_i = 1'b1;
      {wr_we_i, wr_sel_i, wr_data_i} = {1'b1, SP_REG_NUM, 32'h0};
      {pr_we_i, pr_data_i} = {1'b1, 32'hFFFF_FFFF};
      for (int k = 0; k < 40 && init_done_o !== 1'b1; k++)
         @(negedge clk_sys_i);
      quiet();
      chk("done", {31'h0, init_done_o}, 32'h1);
      chk("pc", program_counter_o, 32'h0000_0100);
      chk("sp", stack_pointer_reg_o, 32'h0000_8000);
      chk("pr", return_link_reg_o, DATA_RESET);
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      bad_count++;
      wrap_up();
   end

   // ==========================================================
   // Main sequence
   initial begin
      quiet();
      {rd_a_sel_i, rd_b_sel_i, wr_sel_i, ld_sel_i} = 16'h0000;
      {wr_data_i, ld_data_i, ctl_data_i, pr_data_i} = 128'h0;
      {mac_high_i, mac_low_i, pc_target_i} = 96'h0;
      ld_size_i = CRS_SZ_BYTE;
      ctl_sel_i = CRS_CTL_SR;
      {gbr_disp_i, vec_num_i} = {32'h0000_0020, 8'hFF};
      do_reset();
      foreach (ROWS[i]) begin
         @(negedge clk_sys_i);
         rd_a_sel_i = ROWS[i].sel;
         {ld_sel_i, wr_sel_i} = {2{ROWS[i].sel}};
         ld_size_i = crs_size_t'(ROWS[i].sz);
         {ld_data_i, wr_data_i, ctl_data_i} = {3{ROWS[i].dat}};
         {mac_high_i, mac_low_i, pr_data_i} = {ROWS[i].dat, ~ROWS[i].dat,
            ROWS[i].dat};
         ctl_sel_i = crs_ctl_t'(ROWS[i].sel[1:0]);
         {pr_we_i, mac_we_i, ctl_we_i, wr_we_i, ld_we_i} =
            5'h01 << ROWS[i].kind;
         @(negedge clk_sys_i);
         quiet();
         @(negedge clk_sys_i);
         chk("row", seen(ROWS[i]), ROWS[i].exp);
         if (ROWS[i].kind == 3'h3)
            chk("low", mul_acc_low_o, ~ROWS[i].dat);
      end
      chk("index", index_reg_o, 32'h1234_5678);
      chk("gbr_ea", gbr_ea_o, 32'h0000_1020);
      chk("vec_ea", vec_ea_o, 32'h0000_07FC);
      e = 32'h0000_8000;
      for (int k = 1; k < 4; k++) begin
         @(negedge clk_sys_i);
         {sp_inc_i, sp_dec_i} = k[1:0];
         @(negedge clk_sys_i);
         quiet();
         e = k[0] ? e - STACK_SLOT : e + STACK_SLOT;
         chk("sp_adj", stack_pointer_reg_o, e);
      end
      {pc_target_i, pc_step_i} = {32'h0000_0300, 1'b1};
      @(negedge clk_sys_i);
      chk("pc_step", program_counter_o, 32'h0000_0102);
      pc_load_i = 1'b1;
      @(negedge clk_sys_i);
      quiet();
      chk("pc_load", program_counter_o, 32'h0000_0300);
      // Load and write hit one register; then write beats the push
      {ld_we_i, wr_we_i, sp_dec_i} = 3'h7;
      {ld_sel_i, wr_sel_i, rd_b_sel_i} = 12'h666;
      ld_size_i = CRS_SZ_BYTE;
      {ld_data_i, wr_data_i} = 64'h0000_0001_0000_FFFF;
      @(negedge clk_sys_i);
      {ld_we_i, wr_sel_i, wr_data_i} = {1'b0, SP_REG_NUM, 32'h0000_0040};
      @(negedge clk_sys_i);
      quiet();
      chk("prio_ld", rd_b_data_o, 32'h0000_0001);
      chk("prio_sp", stack_pointer_reg_o, 32'h0000_0040);
      do_reset();
      wrap_up();
   end
endmodule
